// ===== chsi_pkg.sv
/*
 Shared constants, types and helpers for both ends of the host-side link.
 Assumes a 20 MHz core clock on both ends and byte framing of one start
 bit, eight data bits sent LSB first, and one stop bit on each data line.
*/
package chsi_pkg;
   // Core clock period
   localparam int CLK_PERIOD_NS = 50;
   // Bit times for each selectable bitrate
   localparam int BIT_NS_83K = 12000;
   localparam int BIT_NS_125K = 8000;
   localparam int BIT_NS_250K = 4000;
   localparam int BIT_NS_500K = 2000;
   // Bit times in core clock cycles
   localparam logic [7:0] BIT_CYC_83K = 8'(BIT_NS_83K / CLK_PERIOD_NS);
   localparam logic [7:0] BIT_CYC_125K = 8'(BIT_NS_125K / CLK_PERIOD_NS);
   localparam logic [7:0] BIT_CYC_250K = 8'(BIT_NS_250K / CLK_PERIOD_NS);
   localparam logic [7:0] BIT_CYC_500K = 8'(BIT_NS_500K / CLK_PERIOD_NS);
   // Bitrate select codes
   localparam logic [1:0] BR_CODE_83K = 2'h0;
   localparam logic [1:0] BR_CODE_125K = 2'h1;
   localparam logic [1:0] BR_CODE_250K = 2'h2;
   localparam logic [1:0] BR_CODE_500K = 2'h3;
   // Cycles after reset release before the straps are taken
   localparam logic [2:0] STRAP_WAIT = 3'h4;
   // Index of the stop bit within a byte frame
   localparam logic [3:0] LAST_BIT = 4'h9;
   // Internal register bank
   localparam int REG_COUNT = 8;
   localparam logic [2:0] REG_STATUS = 3'h0;
   localparam logic [2:0] REG_CTRL = 3'h1;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam int CTRL_FC_EN_BIT = 0;
   // Command byte layout
   localparam int CMD_WRITE_BIT = 7;
   // Status register fields
   localparam int ST_ASLEEP_BIT = 0;
   localparam int ST_NONEMPTY_BIT = 1;
   localparam int ST_FULL_BIT = 2;
   localparam int ST_READY_BIT = 3;
   localparam int ST_BR_LSB = 4;

   // Command access phase
   typedef enum logic [0:0] {
      CMD_IDLE = 1'b0,
      CMD_WDATA = 1'b1
   } chsi_cmd_t;

   // Bit time in cycles for a bitrate code
   function automatic logic [7:0] bit_cycles(input logic [1:0] code);
      case (code)
         BR_CODE_83K: bit_cycles = BIT_CYC_83K;
         BR_CODE_125K: bit_cycles = BIT_CYC_125K;
         BR_CODE_250K: bit_cycles = BIT_CYC_250K;
         default: bit_cycles = BIT_CYC_500K;
      endcase
   endfunction
endpackage

// ===== chsi_link_if.sv
/*
 Pin-level link between the transceiver and its ECU.
 Assumes both parties run on the same core clock; all pins are one-way.
*/
`timescale 1ns/10ps
interface chsi_link_if;
   logic host_data_out; // Device to ECU serial data, idle high
   logic host_data_in; // ECU to device serial data, idle high
   logic host_cmd_select; // High: bytes go to the register bank
   logic sleep_control_input_n; // Low: device sleeps
   logic bitrate_select_hi; // Bitrate strap, upper bit
   logic bitrate_select_lo; // Bitrate strap, lower bit
   logic host_flow_ready; // Device ready to take ECU bytes

   // Documented device end
   modport dev (
      output host_data_out, host_flow_ready,
      input host_data_in, host_cmd_select, sleep_control_input_n,
      input bitrate_select_hi, bitrate_select_lo
   );
   // ECU end
   modport ecu (
      input host_data_out, host_flow_ready,
      output host_data_in, host_cmd_select, sleep_control_input_n,
      output bitrate_select_hi, bitrate_select_lo
   );
endinterface // chsi_link_if

// ===== chsi_dev.sv
/*
 Device end of the host-side link: receive FIFO toward the ECU, byte
 receiver on the ECU data line, register bank for command access, bitrate
 straps and flow control.
 Assumes the ECU end shares the core clock and that the powerline side
 delivers received bytes through a valid/ready port.
*/
// Function
// (R1) Drive ECU data from FIFO or registers
// (R2) Route ECU bytes to powerline or registers
// (R3) Command select opens register read and write
// (R4) Sample bitrate straps once after reset, hold
// (R5) ECU may send while ready is high
// (R6) ECU pauses sending while ready is low
// (R7) Ship FIFO frame to ECU while ready low
// (R8) Sleep input governs sleep entry and exit
// (R9) Receive FIFO buffers frames during pauses
// (R10) Reset restores defaults, straps resampled afterwards
`timescale 1ns/10ps
module chsi_dev
   import chsi_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int PTR_W = 4
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Link to the ECU
   chsi_link_if.dev link,
   // Bytes received from the powerline
   input wire logic pl_rx_valid_in,
   input wire logic [7:0] pl_rx_data_in,
   output logic pl_rx_ready_out,
   // Bytes bound for the powerline
   output logic pl_tx_valid_out,
   output logic [7:0] pl_tx_data_out,
   // Status
   output logic asleep_out,
   output logic [1:0] bitrate_code_out
);

   // Whole state of the device end
   typedef struct packed {
      logic [2:0] strap_cnt; // Wait before strap capture
      logic br_taken; // Straps captured
      logic [1:0] br_code; // Held bitrate code
      logic rx_busy; // Receiving a byte
      logic [7:0] rx_cnt; // Bit timer
      logic [3:0] rx_bit; // Bit index in frame
      logic [7:0] rx_sh; // Received data bits
      chsi_cmd_t cmd; // Command phase
      logic [2:0] cmd_addr; // Register being written
      logic [REG_COUNT-1:0][7:0] regs; // Register bank
      logic [FIFO_DEPTH-1:0][7:0] mem; // FIFO storage
      logic [PTR_W-1:0] wr_ptr; // FIFO write index
      logic [PTR_W-1:0] rd_ptr; // FIFO read index
      logic [PTR_W:0] count; // FIFO fill
      logic tx_busy; // Shipping a byte
      logic [7:0] tx_cnt; // Bit timer
      logic [3:0] tx_bit; // Bit index in frame
      logic [9:0] tx_sh; // Outgoing frame
      logic rep_valid; // Register reply waiting
      logic [7:0] rep_data; // Register reply value
      logic line_out; // ECU data line
      logic flow_ready; // Ready toward the ECU
      logic pl_tx_valid; // Powerline byte strobe
      logic [7:0] pl_tx_data; // Powerline byte
      logic asleep; // Sleep state
      logic pl_rx_ready; // Awake and FIFO has room
   } chsi_dev_st_t;

   chsi_dev_st_t s_r; // Registered state
   chsi_dev_st_t s_nxt; // Next state
   logic [7:0] bit_len; // Current bit time
   logic byte_done; // Valid byte received
   logic push; // FIFO write
   logic pop; // FIFO read
   logic fc_en; // Flow control enabled
   logic [7:0] status; // Live status byte
   logic rep_set; // Read reply queued this cycle

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      bit_len = bit_cycles(s_r.br_code);
      byte_done = 1'b0;
      pop = 1'b0;
      s_nxt.pl_tx_valid = 1'b0;
      fc_en = s_r.regs[REG_CTRL][CTRL_FC_EN_BIT];
      status = 8'h00;
      rep_set = 1'b0;
      status[ST_ASLEEP_BIT] = s_r.asleep;
      status[ST_NONEMPTY_BIT] = (s_r.count != '0);
      status[ST_FULL_BIT] = (s_r.count == (PTR_W+1)'(FIFO_DEPTH));
      status[ST_READY_BIT] = s_r.flow_ready;
      status[ST_BR_LSB +: 2] = s_r.br_code;

      // Strap capture, once per reset
      if (!s_r.br_taken) begin
         if (s_r.strap_cnt == STRAP_WAIT) begin
            s_nxt.br_taken = 1'b1; // R4
            s_nxt.br_code = {link.bitrate_select_hi, link.bitrate_select_lo}; // R10
         end else begin
            s_nxt.strap_cnt = s_r.strap_cnt + 3'h1;
         end
      end

      // Sleep follows the control pin
      s_nxt.asleep = !link.sleep_control_input_n; // R8

      // Byte receiver on the ECU data line
      if (!s_r.rx_busy) begin
         // Start edge, ignored while asleep or before straps
         if (!link.host_data_in && !s_r.asleep && s_r.br_taken) begin
            s_nxt.rx_busy = 1'b1;
            s_nxt.rx_bit = 4'h0;
            s_nxt.rx_cnt = bit_len >> 1;
         end
      end else if (s_r.rx_cnt != 8'h00) begin
         s_nxt.rx_cnt = s_r.rx_cnt - 8'h01;
      end else begin
         s_nxt.rx_cnt = bit_len - 8'h01;
         s_nxt.rx_bit = s_r.rx_bit + 4'h1;
         if (s_r.rx_bit == 4'h0) begin
            // False start
            if (link.host_data_in) begin
               s_nxt.rx_busy = 1'b0;
            end
         end else if (s_r.rx_bit != LAST_BIT) begin
            s_nxt.rx_sh = {link.host_data_in, s_r.rx_sh[7:1]};
         end else begin
            // Stop bit must be high
            s_nxt.rx_busy = 1'b0;
            byte_done = link.host_data_in;
         end
      end

      // Byte dispatch by the select pin
      if (byte_done) begin
         if (link.host_cmd_select) begin
            if (s_r.cmd == CMD_WDATA) begin
               // Status register is read-only
               if (s_r.cmd_addr != REG_STATUS) begin
                  s_nxt.regs[s_r.cmd_addr] = s_r.rx_sh; // R3
               end
               s_nxt.cmd = CMD_IDLE;
            end else if (s_r.rx_sh[CMD_WRITE_BIT]) begin
               s_nxt.cmd = CMD_WDATA;
               s_nxt.cmd_addr = s_r.rx_sh[2:0];
            end else begin
               rep_set = 1'b1;
               s_nxt.rep_valid = 1'b1; // R3
               s_nxt.rep_data = (s_r.rx_sh[2:0] == REG_STATUS) ? status : s_r.regs[s_r.rx_sh[2:0]];
            end
         end else begin
            // Plain data toward the powerline
            s_nxt.cmd = CMD_IDLE;
            s_nxt.pl_tx_valid = 1'b1; // R2
            s_nxt.pl_tx_data = s_r.rx_sh; // R2
         end
      end

      // Byte transmitter on the ECU data line
      if (s_r.tx_busy) begin
         if (s_r.tx_cnt != 8'h00) begin
            s_nxt.tx_cnt = s_r.tx_cnt - 8'h01;
         end else if (s_r.tx_bit == LAST_BIT) begin
            s_nxt.tx_busy = 1'b0;
         end else begin
            s_nxt.tx_cnt = bit_len - 8'h01;
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
         end
      end else if (s_r.rep_valid) begin
         // Register replies go first
         s_nxt.tx_busy = 1'b1;
         s_nxt.tx_bit = 4'h0;
         s_nxt.tx_cnt = bit_len - 8'h01;
         s_nxt.tx_sh = {1'b1, s_r.rep_data, 1'b0}; // R1
         // A reply queued in this same cycle stays pending
         s_nxt.rep_valid = rep_set;
      end else if ((s_r.count != '0) && !s_r.asleep && (!s_r.flow_ready || !fc_en)) begin
         // Drain the FIFO while awake and ready is low or flow control is off
         s_nxt.tx_busy = 1'b1;
         s_nxt.tx_bit = 4'h0;
         s_nxt.tx_cnt = bit_len - 8'h01;
         s_nxt.tx_sh = {1'b1, s_r.mem[s_r.rd_ptr], 1'b0}; // R7
         s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
         pop = 1'b1;
      end
      s_nxt.line_out = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'b1; // R1

      // FIFO write from the powerline side
      push = pl_rx_valid_in && s_r.pl_rx_ready;
      if (push) begin
         s_nxt.mem[s_r.wr_ptr] = pl_rx_data_in; // R9
         s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
      end
      case ({push, pop})
         2'b10: s_nxt.count = s_r.count + 1'b1;
         2'b01: s_nxt.count = s_r.count - 1'b1;
         default: s_nxt.count = s_r.count;
      endcase
      s_nxt.pl_rx_ready = !s_nxt.asleep && (s_nxt.count < (PTR_W+1)'(FIFO_DEPTH)); // R9

      // Ready high only with nothing left to ship, or awake with flow control off
      if (!s_nxt.regs[REG_CTRL][CTRL_FC_EN_BIT]) begin
         // Never ready while asleep, frames would be ignored
         s_nxt.flow_ready = !s_nxt.asleep; // R5 R8
      end else begin
         s_nxt.flow_ready = !s_nxt.asleep && (s_nxt.count == '0); // R5
      end
   end

   // State register
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_r <= '0; // R10
         s_r.regs[REG_CTRL] <= CTRL_RST;
         s_r.line_out <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign link.host_data_out = s_r.line_out;
   assign link.host_flow_ready = s_r.flow_ready;
   assign pl_rx_ready_out = s_r.pl_rx_ready;
   assign pl_tx_valid_out = s_r.pl_tx_valid;
   assign pl_tx_data_out = s_r.pl_tx_data;
   assign asleep_out = s_r.asleep;
   assign bitrate_code_out = s_r.br_code;

endmodule // chsi_dev

// ===== chsi_ecu.sv
/*
 ECU end of the host-side link: serialises user bytes onto the device
 data input, deserialises the device data output, drives straps and sleep.
 Assumes the device end shares the core clock.
*/
`timescale 1ns/10ps
module chsi_ecu
   import chsi_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Link to the device
   chsi_link_if.ecu link,
   // Configuration
   input wire logic [1:0] bitrate_code_in,
   input wire logic sleep_req_in,
   // Bytes to send
   input wire logic usr_tx_valid_in,
   input wire logic [7:0] usr_tx_data_in,
   input wire logic usr_tx_cmd_in,
   output logic usr_tx_ready_out,
   // Bytes received
   output logic usr_rx_valid_out,
   output logic [7:0] usr_rx_data_out
);

   // Whole state of the ECU end
   typedef struct packed {
      logic [1:0] br_code; // Driven straps
      logic sleep_n; // Driven sleep pin
      logic cmd_sel; // Driven select pin
      logic tx_busy; // Sending a byte
      logic [7:0] tx_cnt; // Bit timer
      logic [3:0] tx_bit; // Bit index
      logic [9:0] tx_sh; // Outgoing frame
      logic line_out; // Data line
      logic tx_ready; // Can take a byte
      logic rx_busy; // Receiving a byte
      logic [7:0] rx_cnt; // Bit timer
      logic [3:0] rx_bit; // Bit index
      logic [7:0] rx_sh; // Received bits
      logic rx_valid; // Byte strobe
      logic [7:0] rx_data; // Received byte
   } chsi_ecu_st_t;

   chsi_ecu_st_t s_r; // Registered state
   chsi_ecu_st_t s_nxt; // Next state
   logic [7:0] bit_len; // Current bit time

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      bit_len = bit_cycles(s_r.br_code);
      s_nxt.br_code = bitrate_code_in;
      s_nxt.sleep_n = !sleep_req_in;
      s_nxt.rx_valid = 1'b0;

      // Transmitter, starts only while the device is ready
      if (s_r.tx_busy) begin
         if (s_r.tx_cnt != 8'h00) begin
            s_nxt.tx_cnt = s_r.tx_cnt - 8'h01;
         end else if (s_r.tx_bit == LAST_BIT) begin
            s_nxt.tx_busy = 1'b0;
         end else begin
            s_nxt.tx_cnt = bit_len - 8'h01;
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
         end
      end else if (usr_tx_valid_in && s_r.tx_ready && link.host_flow_ready) begin
         s_nxt.tx_busy = 1'b1; // R6
         s_nxt.tx_bit = 4'h0;
         s_nxt.tx_cnt = bit_len - 8'h01;
         s_nxt.tx_sh = {1'b1, usr_tx_data_in, 1'b0}; // R2
         s_nxt.cmd_sel = usr_tx_cmd_in; // R3
      end
      s_nxt.line_out = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'b1;
      s_nxt.tx_ready = !s_nxt.tx_busy && link.host_flow_ready; // R5

      // Receiver on the device data line
      if (!s_r.rx_busy) begin
         if (!link.host_data_out) begin
            s_nxt.rx_busy = 1'b1;
            s_nxt.rx_bit = 4'h0;
            s_nxt.rx_cnt = bit_len >> 1;
         end
      end else if (s_r.rx_cnt != 8'h00) begin
         s_nxt.rx_cnt = s_r.rx_cnt - 8'h01;
      end else begin
         s_nxt.rx_cnt = bit_len - 8'h01;
         s_nxt.rx_bit = s_r.rx_bit + 4'h1;
         if (s_r.rx_bit == 4'h0) begin
            // False start
            if (link.host_data_out) begin
               s_nxt.rx_busy = 1'b0;
            end
         end else if (s_r.rx_bit != LAST_BIT) begin
            s_nxt.rx_sh = {link.host_data_out, s_r.rx_sh[7:1]};
         end else begin
            s_nxt.rx_busy = 1'b0;
            s_nxt.rx_valid = link.host_data_out;
            s_nxt.rx_data = s_r.rx_sh;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_r <= '0;
         s_r.sleep_n <= 1'b1;
         s_r.line_out <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign link.host_data_in = s_r.line_out;
   assign link.host_cmd_select = s_r.cmd_sel;
   assign link.sleep_control_input_n = s_r.sleep_n;
   assign link.bitrate_select_hi = s_r.br_code[1];
   assign link.bitrate_select_lo = s_r.br_code[0];
   assign usr_tx_ready_out = s_r.tx_ready;
   assign usr_rx_valid_out = s_r.rx_valid;
   assign usr_rx_data_out = s_r.rx_data;

endmodule // chsi_ecu

// ===== chsi_monitor.sv
/*
 Checker for the pins of the host-side link between device and ECU.
 Assumes one core clock for both ends and straps held steady while frames run.
*/
`timescale 1ns/10ps
module chsi_monitor
   import chsi_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Link pins
   input wire logic host_data_out,
   input wire logic host_data_in,
   input wire logic host_cmd_select,
   input wire logic sleep_control_input_n,
   input wire logic bitrate_select_hi,
   input wire logic bitrate_select_lo,
   input wire logic host_flow_ready
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);
   logic [11:0] bt; // Bit time in cycles from the straps
   logic [11:0] ecnt_r; // Countdown over an ECU frame
   logic [11:0] dcnt_r; // Countdown over a device frame
   logic e_start; // Start bit seen on an idle ECU line
   logic d_start; // Start bit seen on an idle device line

   // Bit time lookup and start detection
   always_comb begin
      bt = {4'h0, bit_cycles({bitrate_select_hi, bitrate_select_lo})};
      e_start = (ecnt_r == 12'h000) && !host_data_in;
      d_start = (dcnt_r == 12'h000) && !host_data_out;
   end

   // Frame countdowns, ten bit times from each start
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ecnt_r <= 12'h000;
         dcnt_r <= 12'h000;
      end else begin
         ecnt_r <= e_start ? bt * 12'h00A - 12'h001 : (ecnt_r != 12'h000 ? ecnt_r - 12'h001 : 12'h000);
         dcnt_r <= d_start ? bt * 12'h00A - 12'h001 : (dcnt_r != 12'h000 ? dcnt_r - 12'h001 : 12'h000);
      end
   end

   a_ecu_bit_hold: assert property ($changed(host_data_in) |=> $stable(host_data_in) [*8])
      else $error("ECU data bit too short");
   a_dev_bit_hold: assert property ($changed(host_data_out) |=> $stable(host_data_out) [*8])
      else $error("Device data bit too short");
   a_ecu_start_low: assert property (ecnt_r > bt * 12'h009 |-> !host_data_in)
      else $error("ECU start bit not low for a bit time");
   a_ecu_stop_high: assert property (ecnt_r != 12'h000 && ecnt_r <= bt |-> host_data_in)
      else $error("ECU stop bit not high");
   a_dev_start_low: assert property (dcnt_r > bt * 12'h009 |-> !host_data_out)
      else $error("Device start bit not low for a bit time");
   a_dev_stop_high: assert property (dcnt_r != 12'h000 && dcnt_r <= bt |-> host_data_out)
      else $error("Device stop bit not high");
   a_ecu_start_flow: assert property (e_start |-> $past(host_flow_ready))
      else $error("ECU frame started while device not ready");
   a_cmd_sel_start: assert property ($changed(host_cmd_select) |-> e_start)
      else $error("Command select moved outside a frame start");
   a_sleep_no_ready: assert property (!sleep_control_input_n [*3] |-> !host_flow_ready)
      else $error("Ready high while asleep");

   // Main scenarios reached
   c_cmd_frame: cover property (e_start && host_cmd_select);
   c_fifo_ship: cover property (d_start && !host_flow_ready);
   c_sleeping: cover property (!sleep_control_input_n [*3]);
endmodule // chsi_monitor

// ===== testbench.sv
/*
 Self-checking bench: device and ECU ends joined by the link interface.
 Assumes a 20 MHz clock; queues predict every byte that surfaces.
*/
`timescale 1ns/10ps
module testbench;
   import chsi_pkg::*;
   logic core_clk_in, rstn_in, pl_rx_valid_in, pl_rx_ready_out, pl_tx_valid_out, asleep_out;
   logic [7:0] pl_rx_data_in, pl_tx_data_out, usr_tx_data_in, usr_rx_data_out, d;
   logic [1:0] bitrate_code_out, bitrate_code_in;
   logic sleep_req_in, usr_tx_valid_in, usr_tx_cmd_in, usr_tx_ready_out, usr_rx_valid_out, seen_full;
   int err_total, n_tests, seed;
   logic [7:0] q_pl[$]; // Bytes expected toward the powerline
   logic [7:0] q_usr[$]; // Bytes expected at the ECU user port
   chsi_link_if lnk ();
   chsi_dev chsi_dev_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .link(lnk),
      .pl_rx_valid_in(pl_rx_valid_in), .pl_rx_data_in(pl_rx_data_in), .pl_rx_ready_out(pl_rx_ready_out),
      .pl_tx_valid_out(pl_tx_valid_out), .pl_tx_data_out(pl_tx_data_out), .asleep_out(asleep_out),
      .bitrate_code_out(bitrate_code_out));
   chsi_ecu chsi_ecu_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .link(lnk),
      .bitrate_code_in(bitrate_code_in), .sleep_req_in(sleep_req_in), .usr_tx_valid_in(usr_tx_valid_in),
      .usr_tx_data_in(usr_tx_data_in), .usr_tx_cmd_in(usr_tx_cmd_in), .usr_tx_ready_out(usr_tx_ready_out),
      .usr_rx_valid_out(usr_rx_valid_out), .usr_rx_data_out(usr_rx_data_out));
   chsi_monitor chsi_monitor_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
      .host_data_out(lnk.host_data_out), .host_data_in(lnk.host_data_in), .host_cmd_select(lnk.host_cmd_select),
      .sleep_control_input_n(lnk.sleep_control_input_n), .bitrate_select_hi(lnk.bitrate_select_hi),
      .bitrate_select_lo(lnk.bitrate_select_lo), .host_flow_ready(lnk.host_flow_ready));

   // Compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Every result popped against the model, mid-cycle while pulses stand
   always @(negedge core_clk_in) begin
      if (pl_tx_valid_out === 1'b1) chk("pl_tx_data", pl_tx_data_out, q_pl.size() ? q_pl.pop_front() : 8'hXX);
      if (usr_rx_valid_out === 1'b1) chk("usr_rx_data", usr_rx_data_out, q_usr.size() ? q_usr.pop_front() : 8'hXX);
   end

   // Reset with a strap code, then check the held code
   task automatic do_reset(input logic [1:0] code);
      rstn_in = 1'b0;
      bitrate_code_in = code;
      repeat (4) @(posedge core_clk_in);
      #1;
      rstn_in = 1'b1;
      repeat (10) @(posedge core_clk_in);
      #1;
      chk("bitrate_code", {6'h00, bitrate_code_out}, {6'h00, code});
   endtask

   // One byte offer: powerline side (pl) or ECU user side
   task automatic xfer(input logic pl, input logic c, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge core_clk_in);
      #1;
      pl_rx_valid_in = pl;
      usr_tx_valid_in = !pl;
      usr_tx_cmd_in = c;
      pl_rx_data_in = v;
      usr_tx_data_in = v;
      if (pl) q_usr.push_back(v);
      else if (!c) q_pl.push_back(v);
      // Held until ready is seen ahead of the taking edge
      while (!(pl ? pl_rx_ready_out === 1'b1 : (usr_tx_ready_out === 1'b1 && lnk.host_flow_ready === 1'b1))
         && n < 9000) begin
         seen_full |= pl;
         @(posedge core_clk_in);
         #1;
         n++;
      end
      @(posedge core_clk_in);
      #1;
      pl_rx_valid_in = 1'b0;
      usr_tx_valid_in = 1'b0;
      if (n >= 9000) chk("offer_wait", 8'h00, 8'h01);
   endtask

   // Wait until the model has seen every expected byte
   task automatic drain();
      int n;
      n = 0;
      while (q_usr.size() + q_pl.size() != 0 && n < 30000) begin
         @(posedge core_clk_in);
         n++;
      end
      @(posedge core_clk_in);
      #1;
      if (n >= 30000) chk("drain_wait", 8'h00, 8'h01);
   endtask

   // Register read through command access
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      q_usr.push_back(exp);
      xfer(1'b0, 1'b1, {5'h00, a});
      drain();
   endtask

   // Register write: address byte then data byte
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      xfer(1'b0, 1'b1, {5'h10, a});
      xfer(1'b0, 1'b1, v);
   endtask

   // Clock
   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   // Watchdog, about twice the expected run
   initial begin
      #3000000;
      err_total++;
      conclude();
   end

   // Main sequence
   initial begin
      seed = 32'hAD1E1E48;
      {pl_rx_valid_in, sleep_req_in, usr_tx_valid_in, usr_tx_cmd_in, seen_full} = 5'h00;
      {pl_rx_data_in, usr_tx_data_in} = 16'h0000;
      // Each strap code: status, data byte, strap held
      for (int code = 0; code < 4; code++) begin
         do_reset(2'(code));
         rd(REG_STATUS, {2'h0, 2'(code), 4'h8});
         xfer(1'b0, 1'b0, 8'($random(seed)));
         drain();
         bitrate_code_in = ~2'(code);
         repeat (20) @(posedge core_clk_in);
         #1;
         chk("bitrate_hold", {6'h00, bitrate_code_out}, 8'(code));
         bitrate_code_in = 2'(code);
         repeat (4) @(posedge core_clk_in);
         #1;
      end
      // Scratch register round trip
      d = 8'($random(seed));
      wr(3'h2, d);
      rd(3'h2, d);
      // Fill the FIFO past full; an ECU byte waits behind the drain
      for (int i = 0; i < 20; i++) begin
         xfer(1'b1, 1'b0, 8'($random(seed)));
         if (i == 2) xfer(1'b0, 1'b0, 8'($random(seed)));
      end
      drain();
      chk("fifo_full_seen", {7'h00, seen_full}, 8'h01);
      // Flow control off: ready stays high with data queued
      wr(REG_CTRL, 8'h00);
      rd(REG_CTRL, 8'h00);
      xfer(1'b1, 1'b0, 8'($random(seed)));
      chk("flow_ready_off", {7'h00, lnk.host_flow_ready}, 8'h01);
      drain();
      // Sleep entry and exit
      sleep_req_in = 1'b1;
      repeat (5) @(posedge core_clk_in);
      #1;
      chk("asleep", {5'h00, asleep_out, pl_rx_ready_out, lnk.host_flow_ready}, 8'h04);
      sleep_req_in = 1'b0;
      repeat (5) @(posedge core_clk_in);
      #1;
      chk("awake", {5'h00, asleep_out, pl_rx_ready_out, lnk.host_flow_ready}, 8'h03);
      // Reset in mid-run restores defaults, after the write has landed
      d = 8'($random(seed)) | 8'h01;
      wr(3'h5, d);
      rd(3'h5, d);
      do_reset(2'h3);
      rd(3'h5, 8'h00);
      rd(REG_CTRL, CTRL_RST);
      conclude();
   end
endmodule // testbench
